// >>> hdl/ind_code_pkg.sv
/*
 * constants and carrier types for the indicate byte encoder: 4b symbol codes,
 * line state codes, receive state nibbles and the fixed special codes.
 * assumes the upstream decoder hands over symbols as control flag plus nibble.
 */
package ind_code_pkg;

   // control symbol nibble codes (control flag set)
   localparam logic [3:0] SYM_H = 4'h1;
   localparam logic [3:0] SYM_T = 4'h5;
   localparam logic [3:0] SYM_R = 4'h6;
   localparam logic [3:0] SYM_S = 4'h7;
   localparam logic [3:0] SYM_I = 4'ha;
   localparam logic [3:0] SYM_J = 4'hd;
   localparam logic [3:0] SYM_K = 4'he;
   localparam logic [3:0] SYM_V = 4'h0;

   // receive state nibbles and mixture replacement
   localparam logic [3:0] RX_INVALID = 4'h3;
   localparam logic [3:0] RX_IDLE = 4'hb;
   localparam logic [3:0] MIX_DATA = 4'h0;

   // fixed special codes
   localparam logic [7:0] CODE_EB_ERR = 8'h3b;
   localparam logic [7:0] CODE_FORCED = 8'h3a;
   localparam logic [7:0] CODE_SCRUB = 8'hb8;

   // known/unknown flag
   localparam logic FLAG_KNOWN = 1'b0;
   localparam logic FLAG_UNKNOWN = 1'b1;

   // line state field
   typedef enum logic [2:0] {
      LS_ACTIVE = 3'b000,
      LS_IDLE = 3'b001,
      LS_NSD = 3'b010,
      LS_MASTER = 3'b100,
      LS_HALT = 3'b101,
      LS_QUIET = 3'b110,
      LS_NOISE = 3'b111
   } line_state_t;

   // one decoded symbol
   typedef struct packed {
      logic ctl;
      logic [3:0] val;
   } sym_t;

   // incoming symbol pair with side conditions
   typedef struct packed {
      sym_t s1;
      sym_t s2;
      logic stuff;
      logic eb_err;
      logic forced;
      logic scrub;
   } pair_in_t;

   // indicate byte toward the mac
   typedef struct packed {
      logic ctl;
      logic [3:0] hi;
      logic [3:0] lo;
   } ind_byte_t;

endpackage

// >>> hdl/ind_skid_buf.sv
/*
 * two-entry buffer with valid/ready on both sides.
 * assumes one clock; in_ready only depends on registered occupancy.
 */
module ind_skid_buf (
   // clock, reset, enable
   input wire logic mclk,
   input wire logic resetn,
   input wire logic ce,
   // fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire ind_code_pkg::ind_byte_t in_data,
   // drain side
   output logic out_valid,
   input wire logic out_ready,
   output ind_code_pkg::ind_byte_t out_data
);

   ind_code_pkg::ind_byte_t mem_q [2];
   logic rd_q;
   logic wr_q;
   logic [1:0] cnt_q;
   logic push;
   logic pop;

   // handshakes only count while enabled, so a frozen buffer drops nothing
   assign push = ce && in_valid && (cnt_q != 2'h2);
   assign pop = ce && out_ready && (cnt_q != 2'h0);

   // storage
   always_ff @(posedge mclk) begin
      if (push) begin
         mem_q[wr_q] <= in_data;
      end
   end

   // pointers and occupancy
   always_ff @(posedge mclk) begin
      if (!resetn) begin
         rd_q <= 1'b0;
         wr_q <= 1'b0;
         cnt_q <= 2'h0;
      end else begin
         if (push) begin
            wr_q <= ~wr_q;
         end
         if (pop) begin
            rd_q <= ~rd_q;
         end
         cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
      end
   end

   assign in_ready = (cnt_q != 2'h2);
   assign out_valid = (cnt_q != 2'h0);
   assign out_data = mem_q[rd_q];

endmodule

// >>> hdl/ind_byte_encoder.sv
/*
 * indicate byte encoder: turns received symbol pairs into the 9-bit
 * indicate byte (control flag and two nibbles) for the mac side.
 * assumes pairs and current line state come from logic on mclk; the
 * line state detector lives upstream. a two-entry buffer absorbs stalls.
 */
// Notes on behaviour
// - every symbol pair becomes one indicate byte carrying data, control or line state.
// - in active line state two data symbols pass unchanged with the control flag clear.
// - in active line state a data/control mixture has its data nibble forced to 0000 and is control.
// - the control flag is set whenever either symbol is V, R, S, T, I or H.
// - a JK pair marks entry to active line state; in active line state it is passed through as control.
// - in idle line state an II pair or a stuff byte gives idle-known, anything else idle-unknown.
// - line state codes carry receive state 0011 for invalid or 1011 for idle in the upper nibble.
// - lower nibble bit 3 is 1 for a mismatch and 0 for a match, bits 2-0 the line state.
// - line state encodes active 000, idle 001, nsd 010, master 100, halt 101, quiet 110, noise 111.
// - in other line states matching symbols or a stuff byte give invalid-known, else invalid-unknown.
// - a stuff byte in idle line state gives idle-known with the idle line state.
// - a stuff byte in another non-active state gives invalid-known with that line state, control set.
module ind_byte_encoder (
   // clock and control
   input wire logic mclk,
   input wire logic resetn,
   input wire logic ce,
   // symbol pair from the decoder
   input wire logic pair_valid,
   output logic pair_ready,
   input wire ind_code_pkg::pair_in_t pair,
   input wire ind_code_pkg::line_state_t line_state,
   // indicate byte to the mac
   output logic ind_valid,
   input wire logic ind_ready,
   output ind_code_pkg::ind_byte_t ind_byte,
   // entry to active line state seen
   output logic jk_seen
);

   ind_code_pkg::ind_byte_t code_d;
   ind_code_pkg::ind_byte_t code_q;
   logic code_vld_q;
   logic buf_in_ready;
   logic buf_out_valid;
   ind_code_pkg::ind_byte_t buf_out_data;
   logic ind_valid_q;
   ind_code_pkg::ind_byte_t ind_byte_q;
   logic jk_seen_q;
   logic take;
   logic stage_free;
   logic out_free;
   logic pair_ready_q;
   logic stage_vld_d;
   logic [1:0] fill_q;
   logic [1:0] fill_d;
   logic fill_push;
   logic fill_pop;

   // true when a symbol equals what the current line state would send
   function automatic logic sym_matches(input ind_code_pkg::sym_t s,
                                        input ind_code_pkg::line_state_t ls);
      logic m;
      m = 1'b0;
      case (ls)
         ind_code_pkg::LS_HALT: m = s.ctl && (s.val == ind_code_pkg::SYM_H);
         ind_code_pkg::LS_MASTER: m = s.ctl &&
            ((s.val == ind_code_pkg::SYM_H) || (s.val == ind_code_pkg::SYM_K));
         ind_code_pkg::LS_QUIET: m = s.ctl && (s.val == ind_code_pkg::SYM_V);
         ind_code_pkg::LS_IDLE: m = s.ctl && (s.val == ind_code_pkg::SYM_I);
         // noise and no signal detect have no defining symbol: any symbol fits
         ind_code_pkg::LS_NOISE: m = 1'b1;
         ind_code_pkg::LS_NSD: m = 1'b1;
         default: m = 1'b0;
      endcase
      return m;
   endfunction

   // encode one pair; special conditions first, then by line state
   always_comb begin
      code_d = '0;
      code_d.ctl = 1'b1;
      if (pair.eb_err) begin
         {code_d.hi, code_d.lo} = ind_code_pkg::CODE_EB_ERR;
      end else if (pair.forced) begin
         {code_d.hi, code_d.lo} = ind_code_pkg::CODE_FORCED;
      end else if (pair.scrub) begin
         {code_d.hi, code_d.lo} = ind_code_pkg::CODE_SCRUB;
      end else begin
         case (line_state)
            ind_code_pkg::LS_ACTIVE: begin
               code_d.ctl = pair.s1.ctl || pair.s2.ctl;
               code_d.hi = pair.s1.val;
               code_d.lo = pair.s2.val;
               if (pair.s1.ctl && !pair.s2.ctl) begin
                  code_d.lo = ind_code_pkg::MIX_DATA;
               end
               if (!pair.s1.ctl && pair.s2.ctl) begin
                  code_d.hi = ind_code_pkg::MIX_DATA;
               end
            end
            ind_code_pkg::LS_IDLE: begin
               code_d.hi = ind_code_pkg::RX_IDLE;
               code_d.lo[2:0] = ind_code_pkg::LS_IDLE;
               if (pair.stuff) begin
                  code_d.lo[3] = ind_code_pkg::FLAG_KNOWN;
               end else if (sym_matches(pair.s1, line_state) &&
                            sym_matches(pair.s2, line_state)) begin
                  code_d.lo[3] = ind_code_pkg::FLAG_KNOWN;
               end else begin
                  code_d.lo[3] = ind_code_pkg::FLAG_UNKNOWN;
               end
            end
            default: begin
               // stuff bytes here are reported as invalid-known, control set
               code_d.hi = ind_code_pkg::RX_INVALID;
               code_d.lo[2:0] = line_state;
               if (pair.stuff || (sym_matches(pair.s1, line_state) &&
                                  sym_matches(pair.s2, line_state))) begin
                  code_d.lo[3] = ind_code_pkg::FLAG_KNOWN;
               end else begin
                  code_d.lo[3] = ind_code_pkg::FLAG_UNKNOWN;
               end
            end
         endcase
      end
   end

   // the stage register moves when empty or when the buffer takes its byte
   assign stage_free = !code_vld_q || buf_in_ready;
   assign take = ce && pair_valid && stage_free;

   // encode stage: one byte per accepted pair
   always_ff @(posedge mclk) begin
      if (!resetn) begin
         code_vld_q <= 1'b0;
         code_q <= '0;
      end else if (ce) begin
         if (stage_free) begin
            code_vld_q <= pair_valid;
         end
         if (take) begin
            code_q <= code_d;
         end
      end
   end

   // start delimiter marker, for the line state detector upstream
   always_ff @(posedge mclk) begin
      if (!resetn) begin
         jk_seen_q <= 1'b0;
      end else if (ce) begin
         jk_seen_q <= take && pair.s1.ctl && pair.s2.ctl &&
            (pair.s1.val == ind_code_pkg::SYM_J) && (pair.s2.val == ind_code_pkg::SYM_K);
      end
   end

   // two-entry buffer so a stalled mac loses no byte
   ind_skid_buf u_buf (
      .mclk(mclk),
      .resetn(resetn),
      .ce(ce),
      .in_valid(code_vld_q),
      .in_ready(buf_in_ready),
      .in_data(code_q),
      .out_valid(buf_out_valid),
      .out_ready(out_free),
      .out_data(buf_out_data)
   );

   // output register: outputs come straight from flip-flops
   assign out_free = !ind_valid_q || ind_ready;

   always_ff @(posedge mclk) begin
      if (!resetn) begin
         ind_valid_q <= 1'b0;
         ind_byte_q <= '0;
      end else if (ce && out_free) begin
         ind_valid_q <= buf_out_valid;
         if (buf_out_valid) begin
            ind_byte_q <= buf_out_data;
         end
      end
   end

   // ready must leave a flip-flop, so it is worked out one cycle ahead from a
   // copy of the buffer occupancy that moves on the very same handshakes
   assign fill_push = ce && code_vld_q && buf_in_ready;
   assign fill_pop = ce && out_free && buf_out_valid;
   assign fill_d = fill_q + {1'b0, fill_push} - {1'b0, fill_pop};
   assign stage_vld_d = (ce && stage_free) ? pair_valid : code_vld_q;

   // registered ready; equals the stage's free condition in every cycle
   always_ff @(posedge mclk) begin
      if (!resetn) begin
         fill_q <= 2'h0;
         pair_ready_q <= 1'b1;
      end else if (ce) begin
         fill_q <= fill_d;
         pair_ready_q <= !stage_vld_d || (fill_d != 2'h2);
      end
   end

   assign pair_ready = pair_ready_q;
   assign ind_valid = ind_valid_q;
   assign ind_byte = ind_byte_q;
   assign jk_seen = jk_seen_q;

endmodule

// >>> verification/ind_enc_sva.sv
/*
 * checker for the indicate byte encoder: reset, hold and code relations.
 * assumes it is bound to ind_byte_encoder and sees only its ports.
 */
module ind_enc_chk (
   // clock and control
   input wire logic mclk,
   input wire logic resetn,
   input wire logic ce,
   // pair side
   input wire logic pair_valid,
   input wire logic pair_ready,
   input wire ind_code_pkg::pair_in_t pair,
   input wire ind_code_pkg::line_state_t line_state,
   // mac side
   input wire logic ind_valid,
   input wire logic ind_ready,
   input wire ind_code_pkg::ind_byte_t ind_byte,
   input wire logic jk_seen
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [2:0] n_q;
   logic tk;
   logic ns;
   logic ii;
   default clocking @(posedge mclk); endclocking
   default disable iff (!resetn);
   assign tk = ce && pair_valid && pair_ready;
   assign ns = !(pair.eb_err || pair.forced || pair.scrub);
   assign ii = pair.s1 == {1'b1, ind_code_pkg::SYM_I} && pair.s2 == {1'b1, ind_code_pkg::SYM_I};
   // bytes in flight; only a pair meeting an empty path has the fixed latency
   always_ff @(posedge mclk) begin
      if (!resetn) begin
         n_q <= 3'h0;
      end else if (ce) begin
         n_q <= n_q + 3'(tk) - 3'(ind_valid && ind_ready);
      end
   end
   sequence lone;
      tk && n_q == 3'h0 && ind_ready ##1 (ce && ind_ready) [*2];
   endsequence
   AST_RESET: assert property (disable iff (1'b0) !resetn |=> !ind_valid && !jk_seen)
      else $error("outputs busy after reset");
   AST_HOLD: assert property (ind_valid && !(ind_ready && ce) |=> ind_valid && $stable(ind_byte))
      else $error("byte dropped or changed while stalled");
   AST_DATA: assert property (ns && line_state == ind_code_pkg::LS_ACTIVE && !pair.s1.ctl &&
      !pair.s2.ctl ##0 lone |=> ind_byte == {1'b0, $past(pair.s1.val, 3), $past(pair.s2.val, 3)})
      else $error("data pair not passed through");
   AST_MIX: assert property (ns && line_state == ind_code_pkg::LS_ACTIVE &&
      pair.s1.ctl != pair.s2.ctl ##0 lone |=> ind_byte == ($past(pair.s1.ctl, 3) ?
      {1'b1, $past(pair.s1.val, 3), 4'h0} : {1'b1, 4'h0, $past(pair.s2.val, 3)}))
      else $error("mixture byte wrong");
   AST_IDLE: assert property (ns && line_state == ind_code_pkg::LS_IDLE ##0 lone |=>
      ind_byte == {1'b1, ind_code_pkg::RX_IDLE, !$past(ii || pair.stuff, 3), 3'h1})
      else $error("idle code wrong");
   AST_OTHER: assert property (ns && line_state != ind_code_pkg::LS_ACTIVE &&
      line_state != ind_code_pkg::LS_IDLE ##0 lone |=> ind_byte.ctl &&
      ind_byte.hi == ind_code_pkg::RX_INVALID && ind_byte.lo[2:0] == $past(line_state, 3))
      else $error("invalid code wrong");
   AST_SPECIAL: assert property (pair.eb_err ##0 lone |=>
      ind_byte == {1'b1, ind_code_pkg::CODE_EB_ERR})
      else $error("overflow code wrong");
   AST_FIXED: assert property (!pair.eb_err && (pair.forced || pair.scrub) ##0 lone |=>
      ind_byte == {1'b1, ($past(pair.forced, 3) ? ind_code_pkg::CODE_FORCED :
      ind_code_pkg::CODE_SCRUB)})
      else $error("forced or scrub code wrong");
   AST_JK: assert property (tk && pair.s1 == {1'b1, ind_code_pkg::SYM_J} &&
      pair.s2 == {1'b1, ind_code_pkg::SYM_K} |=> jk_seen)
      else $error("start delimiter not flagged");
endmodule

bind ind_byte_encoder ind_enc_chk chk_u (.mclk, .resetn, .ce, .pair_valid, .pair_ready,
   .pair, .line_state, .ind_valid, .ind_ready, .ind_byte, .jk_seen);

// >>> verification/mac_sink.sv
/*
 * far-side model: a mac taking indicate bytes, stalling when told.
 * assumes the encoder's valid/ready indicate port on mclk.
 */
module mac_sink (
   // clock and control
   input wire logic mclk,
   input wire logic resetn,
   input wire logic ce,
   // stall request from the bench
   input wire logic stall,
   // indicate port
   input wire logic ind_valid,
   input wire ind_code_pkg::ind_byte_t ind_byte,
   output logic ind_ready
);
   timeunit 1ns;
   timeprecision 100ps;
   ind_code_pkg::ind_byte_t got[$];
   // ready only drops on request; a byte counts when taken with ce high
   assign ind_ready = !stall;
   always @(posedge mclk) begin
      if (resetn && ce && ind_valid && ind_ready) got.push_back(ind_byte);
   end
endmodule

// >>> verification/tb.sv
/*
 * bench for the indicate byte encoder: code table, stall and freeze.
 * assumes mac_sink on the far side and the bound checker.
 */
module tb;
   timeunit 1ns;
   timeprecision 100ps;
   logic mclk = 1'b0;
   logic resetn = 1'b0;
   logic ce = 1'b1;
   logic pair_valid = 1'b0;
   logic stall = 1'b0;
   logic pair_ready, ind_valid, ind_ready, jk_seen;
   ind_code_pkg::pair_in_t pair = '0;
   ind_code_pkg::line_state_t line_state = ind_code_pkg::LS_IDLE;
   ind_code_pkg::ind_byte_t ind_byte;
   logic [8:0] exp_q[$];
   int bad_count = 0;
   int total_checks = 0;
   always #4 mclk = ~mclk;
   ind_byte_encoder dut_u (.mclk, .resetn, .ce, .pair_valid, .pair_ready, .pair,
      .line_state, .ind_valid, .ind_ready, .ind_byte, .jk_seen);
   mac_sink sink_u (.mclk, .resetn, .ce, .stall, .ind_valid, .ind_byte, .ind_ready);
   task automatic chk(logic [8:0] g, logic [8:0] e);
      total_checks++;
      if (g !== e) begin
         bad_count++;
         $display("unexpected at %0t: got %h want %h", $time, g, e);
      end
   endtask
   // one lone pair; the gap lets it clear so the latency stays fixed
   task automatic go(logic [4:0] a, logic [4:0] b, logic [3:0] f, logic [2:0] l, logic [8:0] e);
      logic r;
      pair_valid = 1'b1;
      pair = {a, b, f};
      line_state = ind_code_pkg::line_state_t'(l);
      exp_q.push_back(e);
      do begin
         @(negedge mclk);
         r = pair_ready;
         @(posedge mclk);
      end while (!r);
      #1;
      chk({8'h0, jk_seen}, {8'h0, a == 5'h1d && b == 5'h1e});
      pair_valid = 1'b0;
      repeat (4) @(posedge mclk);
      #1;
   endtask
   task automatic drain();
      int i;
      pair_valid = 1'b0;
      for (i = 0; i < 100 && sink_u.got.size() < exp_q.size(); i++) @(posedge mclk);
      #1;
      chk(9'(sink_u.got.size()), 9'(exp_q.size()));
      for (i = 0; i < exp_q.size(); i++) chk(sink_u.got[i], exp_q[i]);
      exp_q.delete();
      sink_u.got.delete();
   endtask
   task automatic t_codes();
      go(5'h05, 5'h0a, 4'h0, 3'h0, 9'h05a);
      go(5'h03, 5'h15, 4'h0, 3'h0, 9'h105);
      go(5'h15, 5'h09, 4'h0, 3'h0, 9'h150);
      go(5'h16, 5'h17, 4'h0, 3'h0, 9'h167);
      go(5'h10, 5'h11, 4'h0, 3'h0, 9'h101);
      go(5'h1d, 5'h1e, 4'h0, 3'h0, 9'h1de);
      go(5'h1a, 5'h1a, 4'h0, 3'h1, 9'h1b1);
      go(5'h1a, 5'h11, 4'h0, 3'h1, 9'h1b9);
      go(5'h11, 5'h11, 4'h8, 3'h1, 9'h1b1);
      go(5'h11, 5'h11, 4'h0, 3'h5, 9'h135);
      go(5'h1a, 5'h1a, 4'h0, 3'h5, 9'h13d);
      go(5'h10, 5'h10, 4'h0, 3'h6, 9'h136);
      go(5'h05, 5'h05, 4'h0, 3'h4, 9'h13c);
      go(5'h05, 5'h05, 4'h0, 3'h2, 9'h132);
      go(5'h1a, 5'h05, 4'h0, 3'h7, 9'h137);
      go(5'h1a, 5'h1a, 4'h8, 3'h5, 9'h135);
      go(5'h05, 5'h05, 4'h4, 3'h0, 9'h13b);
      go(5'h05, 5'h05, 4'h2, 3'h1, 9'h13a);
      go(5'h1a, 5'h1a, 4'h1, 3'h5, 9'h1b8);
      drain();
   endtask
   // back-to-back pairs into a stalled mac, then a freeze with ce low
   task automatic t_stall();
      int n;
      logic [3:0] k;
      logic r;
      k = 4'h0;
      pair_valid = 1'b1;
      line_state = ind_code_pkg::LS_ACTIVE;
      for (n = 0; n < 12; n++) begin
         stall = n < 4;
         ce = n < 4 || n > 6;
         pair = {1'b0, k, 5'h0f, 4'h0};
         if (n == 7) chk(9'(sink_u.got.size()), 9'h000);
         @(negedge mclk);
         r = pair_ready && ce;
         @(posedge mclk);
         #1;
         if (r) exp_q.push_back({1'b0, k, 4'hf});
         if (r) k++;
      end
      chk({8'h0, k < 4'hc}, 9'h001);
      drain();
   endtask
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   initial begin
      repeat (10) @(posedge mclk);
      #1;
      resetn = 1'b1;
      chk({7'h0, ind_valid, pair_ready}, 9'h001);
      t_codes();
      t_stall();
      wrap_up();
   end
   // watchdog: the whole run needs well under a thousand cycles
   initial begin
      #20000;
      bad_count++;
      wrap_up();
   end
endmodule
